// ### hw/sbm_regs.vh
/*
 * Register map, field positions, status codes and timing of the
 * two-wire master receiver.
 * Assumes a 32-bit AHB-Lite bus with one register per aligned word.
 */
`ifndef SBM_REGS_VH
`define SBM_REGS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses, low address byte)
// ----------------------------------------------------------------
`define SBM_OFS_CTRL   8'h00
`define SBM_OFS_STAT   8'h04
`define SBM_OFS_DATA   8'h08

// ----------------------------------------------------------------
// serial_bus_control fields
// ----------------------------------------------------------------
`define SBM_C_FLAG     7
`define SBM_C_ACK      6
`define SBM_C_STA      5
`define SBM_C_STO      4
`define SBM_C_WCOL     3
`define SBM_C_EN       2
`define SBM_C_IE       0

// ----------------------------------------------------------------
// serial_bus_status fields and codes
// ----------------------------------------------------------------
`define SBM_S_PRE_MSB  1
`define SBM_ST_START   8'h08
`define SBM_ST_RSTART  8'h10
`define SBM_ST_WA_ACK  8'h18
`define SBM_ST_WA_NACK 8'h20
`define SBM_ST_LOST    8'h38
`define SBM_ST_RA_ACK  8'h40
`define SBM_ST_RA_NACK 8'h48
`define SBM_ST_RX_ACK  8'h50
`define SBM_ST_RX_NACK 8'h58
`define SBM_ST_NONE    8'hF8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SBM_DATA_RST   8'hFF
`define SBM_PRE_RST    2'h0

// ----------------------------------------------------------------
// Bit framing and timing
// ----------------------------------------------------------------
`define SBM_ACK_BIT    4'h8
`define SBM_CLK_NS     25
`define SBM_QTR_NS     50
`define SBM_QTR_CYC    ((`SBM_QTR_NS + `SBM_CLK_NS - 1) / `SBM_CLK_NS)

`endif

// ### hw/sbm_sync.v
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes an asynchronous level input; idle level is high.
 */
`timescale 1ns/10ps
module sbm_sync (
   // Clock and control
   input  wire i_ref_clk,
   input  wire i_rst_n,
   input  wire i_clk_en,
   // Level in and out
   input  wire i_async,
   output reg  o_level
);

   reg s1_reg;
   reg s2_reg;
   reg s3_reg;

   // ----------------------------------------------------------------
   // Stages; first one feeds only the second
   // ----------------------------------------------------------------
   always @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         s1_reg  <= 1'b1;
         s2_reg  <= 1'b1;
         s3_reg  <= 1'b1;
         o_level <= 1'b1;
      end else if (i_clk_en) begin
         s1_reg <= i_async;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            o_level <= s3_reg;
         end
      end
   end

endmodule

// ### hw/sbm_master_rx.v
/*
 * Two-wire bus master receiver with AHB-Lite register slave.
 * Assumes open-drain SCL/SDA with external pull-ups and a
 * single AHB-Lite master doing whole-word single transfers.
 */
`include "sbm_regs.vh"
`timescale 1ns/10ps
module sbm_master_rx (
   // Clock, enable, reset
   input  wire        i_ref_clk,
   input  wire        i_clk_en,
   input  wire        i_rst_n,
   // AHB-Lite slave
   input  wire        i_hsel,
   input  wire [31:0] i_haddr,
   input  wire [1:0]  i_htrans,
   input  wire        i_hwrite,
   input  wire [2:0]  i_hsize,
   input  wire [31:0] i_hwdata,
   input  wire        i_hready,
   output reg         o_hreadyout,
   output reg  [31:0] o_hrdata,
   output reg         o_hresp,
   // Two-wire bus pins
   input  wire        i_scl,
   output reg         o_scl_out,
   output reg         o_scl_oe_n,
   input  wire        i_sda,
   output reg         o_sda_out,
   output reg         o_sda_oe_n
);

   localparam [2:0] ST_IDLE  = 3'h0;
   localparam [2:0] ST_START = 3'h1;
   localparam [2:0] ST_BIT   = 3'h2;
   localparam [2:0] ST_HOLD  = 3'h3;
   localparam [2:0] ST_STOP  = 3'h4;
   localparam integer QTR_LAST = `SBM_QTR_CYC - 1;
   localparam [7:0] QTR_LOAD = QTR_LAST[7:0];

   // Bus slave state
   reg         wr_pend_reg;
   reg  [7:0]  wr_addr_reg;
   reg         rd_pend_reg;
   reg  [7:0]  rd_addr_reg;
   // Software-visible state
   reg         flag_reg;
   reg         ack_en_reg;
   reg         sta_reg;
   reg         sto_reg;
   reg         wcol_reg;
   reg         en_reg;
   reg         ie_reg;
   reg  [7:0]  data_reg;
   reg  [7:0]  status_reg;
   reg  [1:0]  pre_reg;
   // Bus engine
   reg  [2:0]  st_reg;
   reg  [1:0]  q_reg;
   reg  [7:0]  tmr_reg;
   reg  [3:0]  bit_reg;
   reg  [7:0]  shift_reg;
   reg         tx_reg;
   reg         dir_rd_reg;
   reg         ackout_reg;
   reg         acked_reg;
   reg         rs_reg;
   reg         busy_reg;
   reg         sda_d_reg;

   wire        scl_lvl;
   wire        sda_lvl;
   wire        addr_ph;
   wire        wr_ctl;
   wire        wr_dat;
   wire        wr_sts;
   wire        tick;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   sbm_sync u_sync_scl (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (i_rst_n),
      .i_clk_en  (i_clk_en),
      .i_async   (i_scl),
      .o_level   (scl_lvl)
   );

   sbm_sync u_sync_sda (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (i_rst_n),
      .i_clk_en  (i_clk_en),
      .i_async   (i_sda),
      .o_level   (sda_lvl)
   );

   // ----------------------------------------------------------------
   // Decode and helpers
   // ----------------------------------------------------------------
   assign addr_ph = i_hsel & i_htrans[1] & i_hready;
   assign wr_ctl  = wr_pend_reg & (wr_addr_reg == `SBM_OFS_CTRL);
   assign wr_dat  = wr_pend_reg & (wr_addr_reg == `SBM_OFS_DATA);
   assign wr_sts  = wr_pend_reg & (wr_addr_reg == `SBM_OFS_STAT);
   // Stretch: the quarter ending in SCL high waits for the wire
   assign tick    = (tmr_reg == 8'h00) & ~((q_reg == 2'h1) & ~scl_lvl);

   function [31:0] rd_val;
      input [7:0] a;
      begin
         case (a)
            `SBM_OFS_CTRL: rd_val = {24'h000000, flag_reg, ack_en_reg, sta_reg, sto_reg,
                                     wcol_reg, en_reg, 1'b0, ie_reg};
            `SBM_OFS_STAT: rd_val = {24'h000000, status_reg[7:3], 1'b0, pre_reg};
            `SBM_OFS_DATA: rd_val = {24'h000000, data_reg};
            default:       rd_val = 32'h00000000;
         endcase
      end
   endfunction

   // Release level (oe_n) of SDA for a given bit slot
   function sda_rel;
      input       t;
      input [3:0] b;
      input [7:0] s;
      input       a;
      begin
         if (b == `SBM_ACK_BIT) begin
            sda_rel = t | ~a;
         end else begin
            sda_rel = ~t | s[7];
         end
      end
   endfunction

   // ----------------------------------------------------------------
   // AHB-Lite slave, zero wait except read right after a write
   // ----------------------------------------------------------------
   always @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         rd_pend_reg <= 1'b0;
         rd_addr_reg <= 8'h00;
         o_hreadyout <= 1'b1;
         o_hrdata    <= 32'h00000000;
         o_hresp     <= 1'b0;
      end else if (i_clk_en) begin
         wr_pend_reg <= addr_ph & i_hwrite;
         if (addr_ph) begin
            wr_addr_reg <= i_haddr[7:0];
         end
         if (rd_pend_reg) begin
            o_hrdata    <= rd_val(rd_addr_reg);
            o_hreadyout <= 1'b1;
            rd_pend_reg <= 1'b0;
         end else if (addr_ph & ~i_hwrite) begin
            // Write lands this edge; read it one cycle later
            if (wr_pend_reg) begin
               rd_pend_reg <= 1'b1;
               rd_addr_reg <= i_haddr[7:0];
               o_hreadyout <= 1'b0;
            end else begin
               o_hrdata <= rd_val(i_haddr[7:0]);
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers and bus engine
   // ----------------------------------------------------------------
   always @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         flag_reg   <= 1'b0;
         ack_en_reg <= 1'b0;
         sta_reg    <= 1'b0;
         sto_reg    <= 1'b0;
         wcol_reg   <= 1'b0;
         en_reg     <= 1'b0;
         ie_reg     <= 1'b0;
         data_reg   <= `SBM_DATA_RST;
         status_reg <= `SBM_ST_NONE;
         pre_reg    <= `SBM_PRE_RST;
         st_reg     <= ST_IDLE;
         q_reg      <= 2'h0;
         tmr_reg    <= 8'h00;
         bit_reg    <= 4'h0;
         shift_reg  <= 8'h00;
         tx_reg     <= 1'b0;
         dir_rd_reg <= 1'b0;
         ackout_reg <= 1'b0;
         acked_reg  <= 1'b0;
         rs_reg     <= 1'b0;
         busy_reg   <= 1'b0;
         sda_d_reg  <= 1'b1;
         o_scl_out  <= 1'b0;
         o_sda_out  <= 1'b0;
         o_scl_oe_n <= 1'b1;
         o_sda_oe_n <= 1'b1;
      end else if (i_clk_en) begin
         // Bus free tracking from START/STOP seen on the wires
         sda_d_reg <= sda_lvl;
         if (scl_lvl & sda_d_reg & ~sda_lvl) begin
            busy_reg <= 1'b1;
         end else if (scl_lvl & ~sda_d_reg & sda_lvl) begin
            busy_reg <= 1'b0;
         end

         if (st_reg != ST_IDLE && st_reg != ST_HOLD) begin
            if (tick) begin
               tmr_reg <= QTR_LOAD;
               q_reg   <= q_reg + 2'h1;
            end else if (tmr_reg != 8'h00) begin
               tmr_reg <= tmr_reg - 8'h01;
            end
         end

         // Software write effects; hardware sets below take priority
         if (wr_ctl) begin
            if (i_hwdata[`SBM_C_FLAG]) begin
               flag_reg <= 1'b0;
            end
            ack_en_reg <= i_hwdata[`SBM_C_ACK];
            sta_reg    <= i_hwdata[`SBM_C_STA];
            sto_reg    <= i_hwdata[`SBM_C_STO];
            en_reg     <= i_hwdata[`SBM_C_EN];
            ie_reg     <= i_hwdata[`SBM_C_IE];
         end
         if (wr_sts) begin
            pre_reg <= i_hwdata[`SBM_S_PRE_MSB:0];
         end
         // Data writes only count while the flag is up
         if (wr_dat) begin
            if (flag_reg) begin
               data_reg <= i_hwdata[7:0];
               wcol_reg <= 1'b0;
            end else begin
               wcol_reg <= 1'b1;
            end
         end

         if (!en_reg) begin
            // Disabled interface lets go of the bus
            st_reg     <= ST_IDLE;
            o_scl_oe_n <= 1'b1;
            o_sda_oe_n <= 1'b1;
         end else begin
            case (st_reg)
               ST_IDLE: begin
                  o_scl_oe_n <= 1'b1;
                  o_sda_oe_n <= 1'b1;
                  if (sto_reg & ~flag_reg & ~wr_ctl) begin
                     sto_reg <= 1'b0;
                  end else if (sta_reg & ~flag_reg & ~busy_reg) begin
                     st_reg  <= ST_START;
                     rs_reg  <= 1'b0;
                     q_reg   <= 2'h0;
                     tmr_reg <= QTR_LOAD;
                  end
               end
               ST_START: begin
                  if (tick) begin
                     case (q_reg)
                        2'h0: o_scl_oe_n <= 1'b1;
                        2'h1: o_sda_oe_n <= 1'b0;
                        2'h2: o_scl_oe_n <= 1'b0;
                        default: begin
                           flag_reg   <= 1'b1;
                           status_reg <= rs_reg ? `SBM_ST_RSTART : `SBM_ST_START;
                           st_reg     <= ST_HOLD;
                        end
                     endcase
                  end
               end
               ST_BIT: begin
                  if (tick) begin
                     case (q_reg)
                        2'h0: o_scl_oe_n <= 1'b1;
                        2'h1: begin
                           if (bit_reg == `SBM_ACK_BIT) begin
                              acked_reg <= ~sda_lvl;
                           end else if (!tx_reg) begin
                              shift_reg <= {shift_reg[6:0], sda_lvl};
                           end
                           // Released SDA read low: another master won
                           if (o_sda_oe_n & ~sda_lvl & (tx_reg ^ (bit_reg == `SBM_ACK_BIT))) begin
                              o_scl_oe_n <= 1'b1;
                              o_sda_oe_n <= 1'b1;
                              flag_reg   <= 1'b1;
                              status_reg <= `SBM_ST_LOST;
                              st_reg     <= ST_IDLE;
                           end
                        end
                        2'h2: o_scl_oe_n <= 1'b0;
                        default: begin
                           if (bit_reg == `SBM_ACK_BIT) begin
                              flag_reg <= 1'b1;
                              st_reg   <= ST_HOLD;
                              if (!tx_reg) begin
                                 o_sda_oe_n <= 1'b1;
                                 data_reg   <= shift_reg;
                                 status_reg <= ackout_reg ? `SBM_ST_RX_ACK : `SBM_ST_RX_NACK;
                              end else if (dir_rd_reg) begin
                                 status_reg <= acked_reg ? `SBM_ST_RA_ACK : `SBM_ST_RA_NACK;
                              end else begin
                                 status_reg <= acked_reg ? `SBM_ST_WA_ACK : `SBM_ST_WA_NACK;
                              end
                           end else begin
                              bit_reg <= bit_reg + 4'h1;
                              if (tx_reg) begin
                                 shift_reg  <= {shift_reg[6:0], 1'b0};
                                 o_sda_oe_n <= sda_rel(tx_reg, bit_reg + 4'h1,
                                                       {shift_reg[6:0], 1'b0}, ackout_reg);
                              end else begin
                                 o_sda_oe_n <= sda_rel(tx_reg, bit_reg + 4'h1, shift_reg, ackout_reg);
                              end
                           end
                        end
                     endcase
                  end
               end
               ST_HOLD: begin
                  o_scl_oe_n <= 1'b0;
                  q_reg      <= 2'h0;
                  tmr_reg    <= QTR_LOAD;
                  if (!flag_reg) begin
                     if (sto_reg) begin
                        st_reg     <= ST_STOP;
                        o_sda_oe_n <= 1'b0;
                     end else if (sta_reg) begin
                        st_reg     <= ST_START;
                        rs_reg     <= 1'b1;
                        o_sda_oe_n <= 1'b1;
                     end else begin
                        case (status_reg)
                           `SBM_ST_START, `SBM_ST_RSTART: begin
                              st_reg     <= ST_BIT;
                              tx_reg     <= 1'b1;
                              bit_reg    <= 4'h0;
                              shift_reg  <= data_reg;
                              dir_rd_reg <= data_reg[0];
                              o_sda_oe_n <= data_reg[7];
                           end
                           `SBM_ST_RA_ACK, `SBM_ST_RX_ACK: begin
                              st_reg     <= ST_BIT;
                              tx_reg     <= 1'b0;
                              bit_reg    <= 4'h0;
                              ackout_reg <= ack_en_reg;
                              o_sda_oe_n <= 1'b1;
                           end
                           default: st_reg <= ST_HOLD;
                        endcase
                     end
                  end
               end
               ST_STOP: begin
                  if (tick) begin
                     case (q_reg)
                        2'h0: o_scl_oe_n <= 1'b1;
                        2'h1: o_sda_oe_n <= 1'b1;
                        2'h2: o_scl_oe_n <= 1'b1;
                        default: begin
                           if (!wr_ctl) begin
                              sto_reg <= 1'b0;
                           end
                           status_reg <= `SBM_ST_NONE;
                           st_reg     <= ST_IDLE;
                        end
                     endcase
                  end
               end
               default: st_reg <= ST_IDLE;
            endcase
         end
      end
   end

endmodule

// ### verification/sbm_slave_model.sv
/* Behavioural slave transmitter for the two-wire bus.
   Assumes tb resolves both pull-up wires from every party's enable. */
`timescale 1ns/10ps
module sbm_slave_model #(
   parameter [6:0] ADDR = 7'h2A
) (
   // Resolved wire levels and slow mode
   input  wire i_scl,
   input  wire i_sda,
   input  wire i_stretch,
   // Pull-downs, low while pulling
   output reg  o_scl_oe_n = 1'b1,
   output reg  o_sda_oe_n = 1'b1,
   // Last acknowledge bit seen from the master
   output reg  o_mack     = 1'b1
);
   // ----------------------------------------------------------------
   // Framing: 0 idle, 1 address, 2 sending, 3 done after NACK
   // ----------------------------------------------------------------
   reg [1:0] ph   = 2'h0;
   reg [3:0] bitc = 4'h0;
   reg [7:0] sh   = 8'h00;
   reg [7:0] tx   = 8'hA5;
   reg       go   = 1'b0;
   always @(negedge i_sda) begin
      if (i_scl === 1'b1) begin
         ph = 2'h1;
         bitc = 4'h0;
         go = 1'b0;
      end
   end
   always @(posedge i_sda) begin
      if (i_scl === 1'b1) begin
         ph = 2'h0;
      end
   end
   always @(posedge i_scl) begin
      if (ph != 2'h0) begin
         if (bitc < 4'h8) begin
            sh = {sh[6:0], i_sda};
         end else if (ph == 2'h2) begin
            o_mack = i_sda;
            tx = tx + 8'h01;
            if (i_sda) begin
               ph = 2'h3;
            end
         end
         bitc = (bitc == 4'h8) ? 4'h0 : bitc + 4'h1;
      end
   end
   // Data changes only while SCL is low; stretching holds it low longer
   always @(negedge i_scl) begin
      if (ph == 2'h1 && bitc == 4'h0 && go) begin
         ph = 2'h2;
      end
      if (ph == 2'h2 && bitc < 4'h8) begin
         o_sda_oe_n = tx[7 - bitc];
      end else if (ph == 2'h1 && bitc == 4'h8 && sh[7:1] == ADDR) begin
         o_sda_oe_n = 1'b0;
         go = sh[0];
      end else begin
         o_sda_oe_n = 1'b1;
      end
      if (i_stretch && ph != 2'h0) begin
         o_scl_oe_n = 1'b0;
         #300;
         o_scl_oe_n = 1'b1;
      end
   end
endmodule

// ### verification/sbm_master_rx_chk.sv
/* Port checker for the two-wire master receiver.
   Assumes one AHB-Lite master and pulled-up open-drain wires. */
`timescale 1ns/10ps
module sbm_master_rx_chk (
   // Clock and reset
   input wire        i_ref_clk,
   input wire        i_rst_n,
   // Register bus
   input wire        i_hsel,
   input wire [31:0] i_haddr,
   input wire [1:0]  i_htrans,
   input wire        i_hwrite,
   input wire [31:0] i_hwdata,
   input wire        i_hready,
   input wire        o_hreadyout,
   input wire [31:0] o_hrdata,
   input wire        o_hresp,
   // Wire drivers
   input wire        o_scl_out,
   input wire        o_scl_oe_n,
   input wire        o_sda_out,
   input wire        o_sda_oe_n
);
   // ----------------------------------------------------------------
   // Transfer decode
   // ----------------------------------------------------------------
   wire rd_take = i_hsel & i_htrans[1] & i_hready & ~i_hwrite;
   wire wr_take = i_hsel & i_htrans[1] & i_hready & i_hwrite;
   reg  ctl_wr_reg;
   always @(posedge i_ref_clk) begin
      ctl_wr_reg <= i_rst_n & wr_take & (i_haddr[7:0] == 8'h00);
   end
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   AST_RST_REL: assert property ($rose(i_rst_n) |-> o_scl_oe_n && o_sda_oe_n && o_hreadyout)
      else $error("lines or bus busy after reset");
   AST_OD_ZERO: assert property (o_scl_out == 1'b0 && o_sda_out == 1'b0)
      else $error("wire driven high");
   AST_OKAY: assert property (o_hresp == 1'b0)
      else $error("response not okay");
   AST_RD_UPPER: assert property (o_hreadyout |-> o_hrdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   AST_WAIT_ONE: assert property (!o_hreadyout |=> o_hreadyout)
      else $error("wait state too long");
   AST_WAIT_CAUSE: assert property ($fell(o_hreadyout) |-> $past(rd_take) && $past(wr_take, 2))
      else $error("wait state without read after write");
   AST_WAIT_NEED: assert property (rd_take && $past(wr_take) |=> !o_hreadyout)
      else $error("read after write not stalled");
   AST_START_CLK: assert property ($fell(o_sda_oe_n) && o_scl_oe_n |-> ##[1:20] !o_scl_oe_n)
      else $error("start not followed by clock low");
   AST_STOP_HOLD: assert property ($rose(o_sda_oe_n) && o_scl_oe_n |=> o_sda_oe_n [*3])
      else $error("data pulled again right after stop");
   AST_DIS_REL: assert property (ctl_wr_reg && !i_hwdata[2] |-> ##3 (o_scl_oe_n && o_sda_oe_n))
      else $error("lines held while disabled");
endmodule
bind sbm_master_rx sbm_master_rx_chk u_chk (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel),
   .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
   .o_hreadyout(o_hreadyout), .o_hrdata(o_hrdata), .o_hresp(o_hresp), .o_scl_out(o_scl_out),
   .o_scl_oe_n(o_scl_oe_n), .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n));

// ### verification/tb.sv
/* Self-checking bench: AHB-Lite master tasks, slave model, scenarios.
   Assumes sbm_regs.vh on the include path. */
`include "sbm_regs.vh"
`timescale 1ns/10ps
module tb;
   localparam [6:0] ADR = 7'h2A;
   reg         clk        = 1'b0;
   reg         rst_n      = 1'b0;
   reg         hsel       = 1'b0;
   reg         hwrite     = 1'b0;
   reg         stretch    = 1'b0;
   // Rival master pulling SDA low
   reg         lose       = 1'b0;
   reg  [1:0]  htrans     = 2'h0;
   reg  [31:0] haddr      = 32'h0;
   reg  [31:0] hwdata     = 32'h0;
   reg  [31:0] rd         = 32'h0;
   reg  [7:0]  exp_b      = 8'hA5;
   integer     error_cnt  = 0;
   integer     n_compared = 0;
   wire        hready;
   wire [31:0] hrdata;
   wire        m_scl_n;
   wire        m_sda_n;
   wire        s_scl_n;
   wire        s_sda_n;
   wire        mack;
   // Pull-ups: low while any party pulls
   wire        scl        = m_scl_n & s_scl_n;
   wire        sda        = m_sda_n & s_sda_n & ~lose;
   always #12.5 clk = ~clk;
   sbm_master_rx u_sbm_master_rx (.i_ref_clk(clk), .i_clk_en(1'b1), .i_rst_n(rst_n), .i_hsel(hsel),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
      .i_hready(hready), .o_hreadyout(hready), .o_hrdata(hrdata), .o_hresp(), .i_scl(scl),
      .o_scl_out(), .o_scl_oe_n(m_scl_n), .i_sda(sda), .o_sda_out(), .o_sda_oe_n(m_sda_n));
   sbm_slave_model #(.ADDR(ADR)) u_sbm_slave_model (.i_scl(scl), .i_sda(sda), .i_stretch(stretch),
      .o_scl_oe_n(s_scl_n), .o_sda_oe_n(s_sda_n), .o_mack(mack));
   // ----------------------------------------------------------------
   // Compare, bus cycles and steps
   // ----------------------------------------------------------------
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         n_compared = n_compared + 1;
         if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("BAD %0t: saw %h, expected %h", $time, seen, exp);
         end
      end
   endtask
   // Entered just after a rising edge; each phase waits for hready
   task ahb(input wr, input [7:0] a, input [31:0] wd);
      begin
         htrans <= 2'h2;
         hsel <= 1'b1;
         hwrite <= wr;
         haddr <= {24'h0, a};
         @(posedge clk);
         while (hready !== 1'b1) @(posedge clk);
         htrans <= 2'h0;
         hwdata <= wd;
         @(posedge clk);
         while (hready !== 1'b1) @(posedge clk);
         rd = hrdata;
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      ahb(1'b1, a, {24'h0, d});
   endtask
   task rdc(input [7:0] a, input [7:0] e);
      begin
         ahb(1'b0, a, 32'h0);
         chk(rd, {24'h0, e});
      end
   endtask
   task wt(input integer b, input v);
      integer i;
      begin
         ahb(1'b0, `SBM_OFS_CTRL, 32'h0);
         for (i = 0; i < 800 && rd[b] !== v; i = i + 1) ahb(1'b0, `SBM_OFS_CTRL, 32'h0);
         chk(rd[b], v);
      end
   endtask
   task ev(input [7:0] code);
      begin
         wt(`SBM_C_FLAG, 1'b1);
         chk(m_scl_n, 1'b0);
         ahb(1'b0, `SBM_OFS_STAT, 32'h0);
         chk(rd & 32'hF8, code);
      end
   endtask
   task rs(input [7:0] c, input [7:0] code);
      begin
         wr(`SBM_OFS_CTRL, c);
         ev(code);
      end
   endtask
   task addr(input [7:0] ab, input [7:0] code);
      begin
         wr(`SBM_OFS_DATA, ab);
         rs(8'h84, code);
      end
   endtask
   task rx(input ack);
      begin
         rs(ack ? 8'hC4 : 8'h84, ack ? `SBM_ST_RX_ACK : `SBM_ST_RX_NACK);
         rdc(`SBM_OFS_DATA, exp_b);
         chk(mack, !ack);
         exp_b = exp_b + 8'h01;
      end
   endtask
   task t_stop;
      begin
         wr(`SBM_OFS_CTRL, 8'h94);
         wt(`SBM_C_STO, 1'b0);
         rdc(`SBM_OFS_STAT, `SBM_ST_NONE);
      end
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task t_regs;
      begin
         rdc(`SBM_OFS_CTRL, 8'h00);
         rdc(`SBM_OFS_STAT, `SBM_ST_NONE);
         rdc(`SBM_OFS_DATA, `SBM_DATA_RST);
         wr(8'h0C, 8'h5A);
         rdc(8'h0C, 8'h00);
         wr(`SBM_OFS_STAT, 8'h03);
         rdc(`SBM_OFS_STAT, 8'hFB);
         wr(`SBM_OFS_STAT, 8'h00);
         wr(`SBM_OFS_DATA, 8'h55);
         rdc(`SBM_OFS_DATA, 8'hFF);
         wr(`SBM_OFS_CTRL, 8'h44);
         htrans <= 2'h2;
         haddr <= 32'h0;
         @(posedge clk);
         ahb(1'b0, `SBM_OFS_CTRL, 32'h44);
         chk(rd, 32'h4C);
      end
   endtask
   task t_read;
      begin
         rs(8'hA4, `SBM_ST_START);
         addr({ADR, 1'b1}, `SBM_ST_RA_ACK);
         rx(1'b1);
         rx(1'b1);
         rx(1'b0);
      end
   endtask
   task t_branch;
      begin
         rs(8'hA4, `SBM_ST_RSTART);
         addr({ADR, 1'b1}, `SBM_ST_RA_ACK);
         rx(1'b0);
         rs(8'hB4, `SBM_ST_START);
         addr({ADR ^ 7'h01, 1'b1}, `SBM_ST_RA_NACK);
         rs(8'hA4, `SBM_ST_RSTART);
         addr({ADR, 1'b0}, `SBM_ST_WA_ACK);
         rs(8'hB4, `SBM_ST_START);
         addr({ADR ^ 7'h01, 1'b1}, `SBM_ST_RA_NACK);
         rs(8'hB4, `SBM_ST_START);
         addr({ADR ^ 7'h01, 1'b1}, `SBM_ST_RA_NACK);
         t_stop;
      end
   endtask
   // Rival holds SDA low under our first released address bit
   task t_lost;
      begin
         rs(8'hA4, `SBM_ST_START);
         wr(`SBM_OFS_DATA, {ADR, 1'b1});
         lose <= 1'b1;
         wr(`SBM_OFS_CTRL, 8'h84);
         wt(`SBM_C_FLAG, 1'b1);
         chk({m_scl_n, m_sda_n}, 2'h3);
         rdc(`SBM_OFS_STAT, `SBM_ST_LOST);
         wr(`SBM_OFS_CTRL, 8'hA4);
         repeat (40) @(posedge clk);
         rdc(`SBM_OFS_CTRL, 8'h24);
         lose <= 1'b0;
         ev(`SBM_ST_START);
         t_stop;
      end
   endtask
   task t_slow;
      begin
         stretch <= 1'b1;
         t_read;
         t_stop;
         stretch <= 1'b0;
      end
   endtask
   task t_disable;
      begin
         rs(8'hA4, `SBM_ST_START);
         wr(`SBM_OFS_CTRL, 8'h80);
         repeat (4) @(posedge clk);
         chk({m_scl_n, m_sda_n}, 2'h3);
      end
   endtask
   task give_verdict;
      begin
         $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
         if (error_cnt == 0 && n_compared > 0) $display("Result: passed");
         else $display("Result: failed");
         $finish;
      end
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      t_regs;
      t_read;
      t_branch;
      t_lost;
      t_slow;
      t_disable;
      give_verdict;
   end
   // Whole run needs well under a tenth of this span
   initial begin
      #2000000;
      error_cnt = error_cnt + 1;
      give_verdict;
   end
endmodule
